// ===== rtl/pmic_pkg.sv
// Constants, register map and state type of the control-pin block.
// Assumes a 10 MHz reference clock and a 32.768 kHz internal tick.
package pmic_pkg;
	localparam int CLK_HZ = 10_000_000;
	localparam int SLOW_HZ = 32_768;
	localparam int SLOW_DIV = CLK_HZ / SLOW_HZ;
	localparam int DIV_W = 9;
	localparam int TCNT_W = 20;
	localparam int DATA_W = 32;
	localparam int ADDR_W = 5;

	// Times in microseconds, turned into slow ticks rounded up
	function automatic int us_to_ticks(input longint us);
		return int'((us * SLOW_HZ + 64'd999_999) / 64'd1_000_000);
	endfunction : us_to_ticks

	localparam longint FAULT_RST_US = 1_800;
	localparam longint FAULT_OFF_US = 100_000;
	localparam longint DBNC_SHORT_US = 31_250;
	localparam longint DBNC_MID_US = 125_000;
	localparam longint DBNC_LONG_US = 750_000;
	localparam longint LONG_PRESS_US = 4_000_000;
	localparam longint STBY_DLY_US = 2_000;
	localparam longint POR_LONG_US = 1_024_000;
	localparam longint POR_US [7] = '{2_000, 3_000, 4_000, 8_000,
		16_000, 32_000, 64_000};

	localparam int FAULT_RST_TICKS = us_to_ticks(FAULT_RST_US);
	localparam int FAULT_OFF_TICKS = us_to_ticks(FAULT_OFF_US);
	localparam int DBNC_SHORT_TICKS = us_to_ticks(DBNC_SHORT_US);
	localparam int DBNC_MID_TICKS = us_to_ticks(DBNC_MID_US);
	localparam int DBNC_LONG_TICKS = us_to_ticks(DBNC_LONG_US);
	localparam int LONG_PRESS_TICKS = us_to_ticks(LONG_PRESS_US);
	localparam int STBY_DLY_TICKS = us_to_ticks(STBY_DLY_US);
	localparam int POR_LONG_TICKS = us_to_ticks(POR_LONG_US);

	// Register byte offsets
	localparam logic [ADDR_W-1:0] REG_CTRL = 5'h00;
	localparam logic [ADDR_W-1:0] REG_CFG = 5'h04;
	localparam logic [ADDR_W-1:0] REG_STATUS = 5'h08;
	localparam logic [ADDR_W-1:0] REG_MASK = 5'h0c;
	localparam logic [ADDR_W-1:0] REG_SENSE = 5'h10;
	localparam logic [ADDR_W-1:0] REG_STATE = 5'h14;

	// Fields of the control and configuration registers
	localparam int CTRL_W = 5;
	localparam int CTRL_INV = 0;
	localparam int CTRL_DLY = 1;
	localparam int CTRL_DBNC = 3;
	localparam int CFG_W = 6;
	localparam int CFG_PG = 0;
	localparam int CFG_POR = 1;
	localparam int CFG_LP = 4;
	localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
	localparam logic [CFG_W-1:0] CFG_RST = 6'h00;

	// Interrupt bits
	localparam int INT_W = 3;
	localparam int INT_PRESS = 0;
	localparam int INT_RELEASE = 1;
	localparam int INT_FAULT = 2;
	localparam logic [INT_W-1:0] MASK_RST = 3'h7;
	localparam logic [INT_W-1:0] INT_BTN = 3'h3;

	// Pin indices and idle levels
	localparam int NPIN = 5;
	localparam int PIN_STBY = 0;
	localparam int PIN_WDI = 1;
	localparam int PIN_BTN = 2;
	localparam int PIN_POWER_ON_INPUT = 3;
	localparam int PIN_FAULT = 4;
	localparam logic [NPIN-1:0] PIN_INIT = 5'h06;

	typedef enum logic [2:0] {
		st_off,
		st_start,
		st_run,
		st_hold,
		st_standby
	} pmic_state_e;
endpackage : pmic_pkg

// ===== rtl/pin_filter.sv
// Two-stage synchroniser and level debouncer for one input pin.
// Assumes a one-cycle slow tick enable from the parent.
`timescale 1ns/1ps
module pin_filter #(
	parameter logic INIT = 1'b0
) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic tick,
	input wire logic pin,
	input wire logic [pmic_pkg::TCNT_W-1:0] rise_ticks,
	input wire logic [pmic_pkg::TCNT_W-1:0] fall_ticks,
	output logic level,
	output logic rise,
	output logic fall
);
	logic sync1_reg;
	logic sync2_reg;
	logic [pmic_pkg::TCNT_W-1:0] cnt_reg;
	wire differ = sync2_reg != level;
	wire [pmic_pkg::TCNT_W-1:0] thr = sync2_reg ? rise_ticks : fall_ticks;
	wire [pmic_pkg::TCNT_W-1:0] cnt_inc =
		pmic_pkg::TCNT_W'(cnt_reg + 1'b1);
	wire settle = tick & differ & (cnt_inc >= thr);

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			sync1_reg <= INIT;
			sync2_reg <= INIT;
			cnt_reg <= '0;
			level <= INIT;
			rise <= 1'b0;
			fall <= 1'b0;
		end else begin
			if (tick) begin
				sync1_reg <= pin;
				sync2_reg <= sync1_reg;
			end
			if (!differ || settle)
				cnt_reg <= '0;
			else if (tick)
				cnt_reg <= cnt_inc;
			if (settle)
				level <= sync2_reg;
			rise <= settle & sync2_reg;
			fall <= settle & ~sync2_reg;
		end
	end
endmodule : pin_filter

// ===== rtl/pmic_control_pin_logic.sv
// Control-pin logic: standby, host reset, interrupt, watchdog, button.
// Assumes asynchronous pins, 10 MHz ref_clk and an Avalon-MM master.
//
// Local design decisions: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
module pmic_control_pin_logic #(
	parameter int DBNC_LONG_TICKS = pmic_pkg::DBNC_LONG_TICKS,
	parameter int LONG_PRESS_TICKS = pmic_pkg::LONG_PRESS_TICKS,
	parameter int POR_LONG_TICKS = pmic_pkg::POR_LONG_TICKS
) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic [pmic_pkg::ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [pmic_pkg::DATA_W-1:0] avs_writedata,
	output logic [pmic_pkg::DATA_W-1:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic standby_pin,
	input wire logic watchdog_input,
	input wire logic power_button,
	input wire logic power_on_input,
	input wire logic fault_in,
	input wire logic sequence_done,
	output logic regulators_enable,
	output logic standby_active,
	output logic host_reset_n_out,
	output logic host_reset_n_oe_n,
	output logic interrupt_out_n_out,
	output logic interrupt_out_n_oe_n
);
	localparam int TW = pmic_pkg::TCNT_W;
	localparam logic [TW-1:0] ONE_T = 20'h00001;
	localparam logic [TW-1:0] SHORT_T = TW'(pmic_pkg::DBNC_SHORT_TICKS);
	localparam logic [TW-1:0] MID_T = TW'(pmic_pkg::DBNC_MID_TICKS);
	localparam logic [TW-1:0] LONG_T = TW'(DBNC_LONG_TICKS);
	localparam logic [TW-1:0] FRST_T = TW'(pmic_pkg::FAULT_RST_TICKS);
	localparam logic [TW-1:0] FOFF_T = TW'(pmic_pkg::FAULT_OFF_TICKS);
	localparam logic [TW-1:0] SDLY_T = TW'(pmic_pkg::STBY_DLY_TICKS);
	localparam logic [TW-1:0] LP_T = TW'(LONG_PRESS_TICKS);
	localparam logic [TW-1:0] PLONG_T = TW'(POR_LONG_TICKS);
	localparam logic [TW-1:0] TMAX = '1;
	localparam logic [pmic_pkg::DIV_W-1:0] DIV_LAST =
		pmic_pkg::DIV_W'(pmic_pkg::SLOW_DIV - 1);

	////////////////////////////////////////////////////////////////////
	// Slow tick divider

	logic [pmic_pkg::DIV_W-1:0] div_reg;
	logic tick_reg;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			div_reg <= '0;
			tick_reg <= 1'b0;
		end else begin
			div_reg <= (div_reg == DIV_LAST) ? '0 :
				pmic_pkg::DIV_W'(div_reg + 1'b1);
			tick_reg <= div_reg == DIV_LAST;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Registers

	logic [pmic_pkg::CTRL_W-1:0] ctrl_reg;
	logic [pmic_pkg::CFG_W-1:0] cfg_reg;
	logic [pmic_pkg::INT_W-1:0] status_reg;
	logic [pmic_pkg::INT_W-1:0] status_next;
	logic [pmic_pkg::INT_W-1:0] mask_reg;
	logic ack_reg;

	wire standby_invert = ctrl_reg[pmic_pkg::CTRL_INV];
	wire [1:0] standby_delay_select = ctrl_reg[pmic_pkg::CTRL_DLY +: 2];
	wire [1:0] button_debounce = ctrl_reg[pmic_pkg::CTRL_DBNC +: 2];
	wire power_good_reset_enable = cfg_reg[pmic_pkg::CFG_PG];
	wire [2:0] reset_release_delay = cfg_reg[pmic_pkg::CFG_POR +: 3];
	wire [1:0] long_press_time = cfg_reg[pmic_pkg::CFG_LP +: 2];

	////////////////////////////////////////////////////////////////////
	// Pin qualification

	wire [pmic_pkg::NPIN-1:0] pin_raw = {fault_in, power_on_input,
		power_button, watchdog_input, standby_pin};
	logic [pmic_pkg::NPIN-1:0] lvl;
	logic [pmic_pkg::NPIN-1:0] up;
	logic [pmic_pkg::NPIN-1:0] down;
	logic [TW-1:0] press_t;

	assign press_t = (button_debounce == 2'h2) ? MID_T :
		(button_debounce == 2'h3) ? LONG_T : SHORT_T;

	genvar gi;
	generate
		for (gi = 0; gi < pmic_pkg::NPIN; gi++) begin : g_pin
			wire is_btn = gi == pmic_pkg::PIN_BTN;
			pin_filter #(
				.INIT(pmic_pkg::PIN_INIT[gi])
			) u_filt (
				.ref_clk(ref_clk),
				.reset(reset),
				.tick(tick_reg),
				.pin(pin_raw[gi]),
				.rise_ticks(is_btn ? SHORT_T : ONE_T),
				.fall_ticks(is_btn ? press_t : ONE_T),
				.level(lvl[gi]),
				.rise(up[gi]),
				.fall(down[gi])
			);
		end
	endgenerate

	wire btn_pressed = ~lvl[pmic_pkg::PIN_BTN];
	wire standby_req = lvl[pmic_pkg::PIN_STBY] ^ standby_invert;
	wire pwr_on = lvl[pmic_pkg::PIN_POWER_ON_INPUT];
	wire fault_lvl = lvl[pmic_pkg::PIN_FAULT];
	wire wdi_low = ~lvl[pmic_pkg::PIN_WDI];

	////////////////////////////////////////////////////////////////////
	// Timers

	pmic_pkg::pmic_state_e state_reg;
	pmic_pkg::pmic_state_e state_next;
	logic [TW-1:0] fault_cnt_reg;
	logic [TW-1:0] press_cnt_reg;
	logic [TW-1:0] dly_cnt_reg;
	logic fault_seen_reg;
	logic rearm_reg;

	wire [TW-1:0] fault_inc = TW'(fault_cnt_reg + 1'b1);
	wire [TW-1:0] press_inc = TW'(press_cnt_reg + 1'b1);
	wire [TW-1:0] dly_inc = TW'(dly_cnt_reg + 1'b1);
	wire [TW-1:0] lp_limit = TW'(LP_T * (long_press_time + 3'h1));
	wire [TW-1:0] stby_limit = TW'(SDLY_T * standby_delay_select);
	wire [TW-1:0] por_limit;

	assign por_limit = (reset_release_delay == 3'h7) ? PLONG_T :
		TW'(pmic_pkg::us_to_ticks(64'd0) +
		pmic_pkg::us_to_ticks(pmic_pkg::POR_US[reset_release_delay]));

	wire fault_rst = fault_cnt_reg >= FRST_T;
	wire fault_kill = power_good_reset_enable & (fault_cnt_reg > FOFF_T);
	wire long_hit = press_cnt_reg > lp_limit;
	wire sys_on = (state_reg == pmic_pkg::st_run) |
		(state_reg == pmic_pkg::st_hold) |
		(state_reg == pmic_pkg::st_standby);
	wire wdi_kill = wdi_low & sys_on;
	wire turn_off = (state_reg != pmic_pkg::st_off) & ~pwr_on;
	wire force_off = long_hit | fault_kill | wdi_kill | turn_off;
	wire counting = (state_reg == pmic_pkg::st_start) ? sequence_done :
		(state_reg == pmic_pkg::st_hold);

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			fault_cnt_reg <= '0;
			press_cnt_reg <= '0;
			dly_cnt_reg <= '0;
		end else begin
			if (!fault_lvl)
				fault_cnt_reg <= '0;
			else if (tick_reg && fault_cnt_reg != TMAX)
				fault_cnt_reg <= fault_inc;
			if (!btn_pressed)
				press_cnt_reg <= '0;
			else if (tick_reg && press_cnt_reg != TMAX)
				press_cnt_reg <= press_inc;
			if (state_next != state_reg || !counting)
				dly_cnt_reg <= '0;
			else if (tick_reg && dly_cnt_reg != TMAX)
				dly_cnt_reg <= dly_inc;
		end
	end

	////////////////////////////////////////////////////////////////////
	// System state

	wire por_done = dly_cnt_reg >= por_limit;
	wire start_ok = ~(power_good_reset_enable & fault_seen_reg);

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			pmic_pkg::st_off: begin
				if (pwr_on && !rearm_reg)
					state_next = pmic_pkg::st_start;
			end
			pmic_pkg::st_start: begin
				if (sequence_done && por_done && start_ok)
					state_next = pmic_pkg::st_run;
			end
			pmic_pkg::st_run: begin
				if (standby_req)
					state_next = (standby_delay_select == 2'h0) ?
						pmic_pkg::st_standby : pmic_pkg::st_hold;
			end
			pmic_pkg::st_hold: begin
				if (!standby_req)
					state_next = pmic_pkg::st_run;
				else if (dly_cnt_reg >= stby_limit)
					state_next = pmic_pkg::st_standby;
			end
			pmic_pkg::st_standby: begin
				if (!standby_req)
					state_next = pmic_pkg::st_run;
			end
			default: state_next = pmic_pkg::st_off;
		endcase
		if (force_off)
			state_next = pmic_pkg::st_off;
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			state_reg <= pmic_pkg::st_off;
			fault_seen_reg <= 1'b0;
			rearm_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			if (state_reg == pmic_pkg::st_off)
				fault_seen_reg <= 1'b0;
			else if (state_reg == pmic_pkg::st_start && fault_lvl)
				fault_seen_reg <= 1'b1;
			if (force_off)
				rearm_reg <= 1'b1;
			else if (!pwr_on)
				rearm_reg <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Pin outputs

	wire sys_off = (state_reg == pmic_pkg::st_off) |
		(state_reg == pmic_pkg::st_start);
	wire rst_assert = sys_off | (power_good_reset_enable & fault_rst);
	wire int_assert = |(status_next & ~mask_reg);

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			host_reset_n_out <= 1'b0;
			host_reset_n_oe_n <= 1'b0;
			interrupt_out_n_out <= 1'b0;
			interrupt_out_n_oe_n <= 1'b1;
			regulators_enable <= 1'b0;
			standby_active <= 1'b0;
		end else begin
			host_reset_n_out <= 1'b0;
			host_reset_n_oe_n <= ~rst_assert;
			interrupt_out_n_out <= 1'b0;
			interrupt_out_n_oe_n <= ~int_assert;
			regulators_enable <= state_next != pmic_pkg::st_off;
			standby_active <= state_next == pmic_pkg::st_standby;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Avalon slave

	wire req = avs_read | avs_write;
	wire wr_go = avs_write & ack_reg;
	wire sel_ctrl = avs_address == pmic_pkg::REG_CTRL;
	wire sel_cfg = avs_address == pmic_pkg::REG_CFG;
	wire sel_status = avs_address == pmic_pkg::REG_STATUS;
	wire sel_mask = avs_address == pmic_pkg::REG_MASK;
	wire sel_sense = avs_address == pmic_pkg::REG_SENSE;
	wire sel_state = avs_address == pmic_pkg::REG_STATE;
	wire [pmic_pkg::INT_W-1:0] clr = (wr_go & sel_status) ?
		avs_writedata[pmic_pkg::INT_W-1:0] : '0;
	wire [pmic_pkg::INT_W-1:0] set = {up[pmic_pkg::PIN_FAULT],
		up[pmic_pkg::PIN_BTN], down[pmic_pkg::PIN_BTN]};
	wire [pmic_pkg::INT_W-1:0] off_clr =
		(state_reg == pmic_pkg::st_off) ? pmic_pkg::INT_BTN : '0;
	wire [pmic_pkg::NPIN-1:0] sense = {fault_lvl, pwr_on, btn_pressed,
		wdi_low, standby_req};
	wire [pmic_pkg::DATA_W-1:0] rd_mux =
		sel_ctrl ? pmic_pkg::DATA_W'(ctrl_reg) :
		sel_cfg ? pmic_pkg::DATA_W'(cfg_reg) :
		sel_status ? pmic_pkg::DATA_W'(status_reg) :
		sel_mask ? pmic_pkg::DATA_W'(mask_reg) :
		sel_sense ? pmic_pkg::DATA_W'(sense) :
		sel_state ? pmic_pkg::DATA_W'(state_reg) : '0;

	// Set wins over a same-cycle clear
	assign status_next = (status_reg & ~clr & ~off_clr) | set;
	assign avs_waitrequest = req & ~ack_reg;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			ack_reg <= 1'b0;
			avs_readdata <= '0;
		end else begin
			ack_reg <= req & ~ack_reg;
			if (avs_read && !ack_reg)
				avs_readdata <= rd_mux;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			ctrl_reg <= pmic_pkg::CTRL_RST;
			cfg_reg <= pmic_pkg::CFG_RST;
			mask_reg <= pmic_pkg::MASK_RST;
			status_reg <= '0;
		end else begin
			status_reg <= status_next;
			if (wr_go && sel_ctrl)
				ctrl_reg <= avs_writedata[pmic_pkg::CTRL_W-1:0];
			if (wr_go && sel_cfg)
				cfg_reg <= avs_writedata[pmic_pkg::CFG_W-1:0];
			if (wr_go && sel_mask)
				mask_reg <= avs_writedata[pmic_pkg::INT_W-1:0];
		end
	end
endmodule : pmic_control_pin_logic

// ===== testbench/pmic_control_pin_logic_checker.sv
// Checker of the bus, reset, interrupt and standby relations.
// Assumes binding to the block's ports and a 305-clock slow tick.
`timescale 1ns/1ps
module pmic_control_pin_logic_checker (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic [pmic_pkg::ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [pmic_pkg::DATA_W-1:0] avs_writedata,
	input wire logic avs_waitrequest,
	input wire logic watchdog_input,
	input wire logic sequence_done,
	input wire logic regulators_enable,
	input wire logic standby_active,
	input wire logic host_reset_n_out,
	input wire logic host_reset_n_oe_n,
	input wire logic interrupt_out_n_out,
	input wire logic interrupt_out_n_oe_n
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	////////////////////////////////////////
	// Shadow of the mask, watchdog counter
	logic [pmic_pkg::INT_W-1:0] mask_reg;
	logic [11:0] wd_reg;
	wire mask_wr = avs_write && !avs_waitrequest
		&& avs_address == pmic_pkg::REG_MASK;
	wire wd_run = !watchdog_input && regulators_enable
		&& (host_reset_n_oe_n || wd_reg != 12'h0);
	always_ff @(posedge ref_clk) begin
		if (reset)
			mask_reg <= pmic_pkg::MASK_RST;
		else if (mask_wr)
			mask_reg <= avs_writedata[pmic_pkg::INT_W-1:0];
	end
	always_ff @(posedge ref_clk) begin
		if (reset || !wd_run)
			wd_reg <= 12'h0;
		else
			wd_reg <= wd_reg + 12'h1;
	end
	////////////////////////////////////////
	a_bus_one_wait: assert property ((avs_read || avs_write)
		&& avs_waitrequest |=> !avs_waitrequest)
		else $error("bus wait longer than one cycle");
	a_bus_idle_ready: assert property (!(avs_read || avs_write)
		|-> !avs_waitrequest) else $error("waitrequest without request");
	a_reset_values: assert property ($fell(reset)
		|-> interrupt_out_n_oe_n && !host_reset_n_oe_n && !regulators_enable)
		else $error("outputs not at reset values");
	a_off_reset_low: assert property (!regulators_enable
		&& $past(!regulators_enable) |-> !host_reset_n_oe_n)
		else $error("host reset released while off");
	a_release_after_seq: assert property ($rose(host_reset_n_oe_n)
		|-> regulators_enable && $past(sequence_done, 2))
		else $error("host reset released before start-up done");
	a_standby_from_run: assert property ($rose(standby_active)
		|-> $past(host_reset_n_oe_n) && regulators_enable)
		else $error("standby entered outside run");
	a_open_drain_low: assert property (!host_reset_n_out
		&& !interrupt_out_n_out) else $error("open-drain data not low");
	a_masked_int_quiet: assert property (mask_reg == pmic_pkg::MASK_RST
		&& $past(mask_reg) == pmic_pkg::MASK_RST |-> interrupt_out_n_oe_n)
		else $error("interrupt pin low with all masked");
	a_watchdog_hard_off: assert property (wd_reg < 12'h514)
		else $error("watchdog low did not turn regulators off");
	cover property ($rose(standby_active));
	cover property ($fell(interrupt_out_n_oe_n));
	cover property ($rose(host_reset_n_oe_n));
	cover property ($fell(regulators_enable) && !watchdog_input);
endmodule : pmic_control_pin_logic_checker

bind pmic_control_pin_logic pmic_control_pin_logic_checker chk (
	.ref_clk(ref_clk), .reset(reset), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
	.watchdog_input(watchdog_input), .sequence_done(sequence_done),
	.regulators_enable(regulators_enable), .standby_active(standby_active),
	.host_reset_n_out(host_reset_n_out),
	.host_reset_n_oe_n(host_reset_n_oe_n),
	.interrupt_out_n_out(interrupt_out_n_out),
	.interrupt_out_n_oe_n(interrupt_out_n_oe_n));

// ===== testbench/host_button_model.sv
// Host processor and push-button model, pull-ups on open-drain lines.
// Assumes the bench commands the watchdog through wd_fire.
`timescale 1ns/1ps
module host_button_model (
	input wire logic wd_fire,
	input wire logic press,
	input wire logic host_reset_n_out,
	input wire logic host_reset_n_oe_n,
	input wire logic interrupt_out_n_out,
	input wire logic interrupt_out_n_oe_n,
	output logic watchdog_input,
	output logic power_button,
	output logic host_reset_wire,
	output logic interrupt_wire
);
	assign host_reset_wire = host_reset_n_oe_n ? 1'b1 : host_reset_n_out;
	assign interrupt_wire = interrupt_out_n_oe_n ? 1'b1 : interrupt_out_n_out;
	// watchdog fired only by a running host
	assign watchdog_input = !(wd_fire && host_reset_wire);
	// switch pulls the line low while pressed
	assign power_button = !press;
endmodule : host_button_model

// ===== testbench/test_pmic_control_pin_logic.sv
// Self-checking bench of the control-pin block.
// Assumes the host model beside the block and shortened long counts.
`timescale 1ns/1ps
module test_pmic_control_pin_logic;
	localparam int TK = 305;
	typedef struct packed {
		logic wr;
		logic [pmic_pkg::ADDR_W-1:0] a;
		logic [31:0] d;
		logic [31:0] e;
	} bus_row_s;
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	logic [pmic_pkg::ADDR_W-1:0] avs_address = 5'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [pmic_pkg::DATA_W-1:0] avs_writedata = 32'h0;
	logic [pmic_pkg::DATA_W-1:0] avs_readdata;
	logic avs_waitrequest;
	logic standby_pin = 1'b0;
	logic power_on_input = 1'b0;
	logic fault_in = 1'b0;
	logic sequence_done = 1'b0;
	logic wd_fire = 1'b0;
	logic press = 1'b0;
	logic watchdog_input, power_button, host_reset_wire, interrupt_wire;
	logic regulators_enable, standby_active;
	logic host_reset_n_out, host_reset_n_oe_n;
	logic interrupt_out_n_out, interrupt_out_n_oe_n;
	int mismatches = 0;
	int checks = 0;
	int n;
	logic [31:0] q;
	bus_row_s rows [20] = '{
		'{1'b0, pmic_pkg::REG_CTRL, 32'h0, 32'h0},
		'{1'b0, pmic_pkg::REG_CFG, 32'h0, 32'h0},
		'{1'b0, pmic_pkg::REG_STATUS, 32'h0, 32'h0},
		'{1'b0, pmic_pkg::REG_MASK, 32'h0, 32'h7},
		'{1'b0, pmic_pkg::REG_STATE, 32'h0, 32'h0},
		'{1'b0, 5'h18, 32'h0, 32'h0},
		'{1'b1, pmic_pkg::REG_CTRL, 32'hffffffff, 32'h0},
		'{1'b0, pmic_pkg::REG_CTRL, 32'h0, 32'h1f},
		'{1'b1, pmic_pkg::REG_CFG, 32'h3f, 32'h0},
		'{1'b0, pmic_pkg::REG_CFG, 32'h0, 32'h3f},
		'{1'b1, pmic_pkg::REG_MASK, 32'h0, 32'h0},
		'{1'b0, pmic_pkg::REG_MASK, 32'h0, 32'h0},
		'{1'b1, pmic_pkg::REG_STATE, 32'h3, 32'h0},
		'{1'b0, pmic_pkg::REG_STATE, 32'h0, 32'h0},
		'{1'b1, 5'h1c, 32'h5, 32'h0},
		'{1'b0, 5'h1c, 32'h0, 32'h0},
		'{1'b1, pmic_pkg::REG_MASK, 32'h7, 32'h0},
		'{1'b1, pmic_pkg::REG_CTRL, 32'h0, 32'h0},
		'{1'b1, pmic_pkg::REG_CFG, 32'h0f, 32'h0},
		'{1'b0, pmic_pkg::REG_SENSE, 32'h0, 32'h0}};
	////////////////////////////////////////
	pmic_control_pin_logic #(.DBNC_LONG_TICKS(8), .LONG_PRESS_TICKS(10),
		.POR_LONG_TICKS(30)) dut (.ref_clk(ref_clk), .reset(reset),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.standby_pin(standby_pin), .watchdog_input(watchdog_input),
		.power_button(power_button), .power_on_input(power_on_input),
		.fault_in(fault_in), .sequence_done(sequence_done),
		.regulators_enable(regulators_enable),
		.standby_active(standby_active),
		.host_reset_n_out(host_reset_n_out),
		.host_reset_n_oe_n(host_reset_n_oe_n),
		.interrupt_out_n_out(interrupt_out_n_out),
		.interrupt_out_n_oe_n(interrupt_out_n_oe_n));
	host_button_model host (.wd_fire(wd_fire), .press(press),
		.host_reset_n_out(host_reset_n_out),
		.host_reset_n_oe_n(host_reset_n_oe_n),
		.interrupt_out_n_out(interrupt_out_n_out),
		.interrupt_out_n_oe_n(interrupt_out_n_oe_n),
		.watchdog_input(watchdog_input), .power_button(power_button),
		.host_reset_wire(host_reset_wire), .interrupt_wire(interrupt_wire));
	always #50 ref_clk = ~ref_clk;
	////////////////////////////////////////
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : print_verdict
	task automatic check(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		checks++;
		if (g !== e) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask : check
	task automatic bus(input logic w, input logic [4:0] a,
		input logic [31:0] d, output logic [31:0] r);
		int k;
		k = 0;
		@(posedge ref_clk);
		avs_read <= !w;
		avs_write <= w;
		avs_address <= a;
		avs_writedata <= d;
		do begin
			@(posedge ref_clk);
			k++;
		end while (avs_waitrequest !== 1'b0 && k < 50);
		check("bus_wait", 32'h0, {31'h0, avs_waitrequest});
		r = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus
	function automatic logic pick(input int s);
		case (s)
			0: return host_reset_wire;
			1: return standby_active;
			default: return regulators_enable;
		endcase
	endfunction : pick
	task automatic wait_for(input int s, input logic v, input int lim);
		n = 0;
		while (pick(s) !== v && n < lim) begin
			@(posedge ref_clk);
			n++;
		end
		check("wait", {31'h0, v}, {31'h0, pick(s)});
	endtask : wait_for
	task automatic sby(input logic [31:0] c, input logic p, input logic v,
		input int lo, input int hi);
		bus(1'b1, pmic_pkg::REG_CTRL, c, q);
		standby_pin <= p;
		wait_for(1, v, 80 * TK);
		check("standby", {31'h0, v}, {31'h0, standby_active});
		check("standby_time", 32'h1, {31'h0, n >= lo && n <= hi});
	endtask : sby
	////////////////////////////////////////
	initial begin
		repeat (95000) @(posedge ref_clk);
		mismatches++;
		print_verdict();
	end
	initial begin
		repeat (16) @(posedge ref_clk);
		reset <= 1'b0;
		foreach (rows[i]) begin
			bus(rows[i].wr, rows[i].a, rows[i].d, q);
			if (!rows[i].wr)
				check("reg_read", rows[i].e, q);
		end
		power_on_input <= 1'b1;
		sequence_done <= 1'b1;
		wait_for(0, 1'b1, 60 * TK);
		check("release", 32'h1, {31'h0, n >= 31 * TK && n <= 37 * TK});
		check("regs_on", 32'h1, {31'h0, regulators_enable});
		sby(32'h0, 1'b1, 1'b1, 2 * TK, 5 * TK);
		sby(32'h0, 1'b0, 1'b0, 2 * TK, 5 * TK);
		sby(32'h1, 1'b0, 1'b1, 0, 5 * TK);
		sby(32'h1, 1'b1, 1'b0, 2 * TK, 5 * TK);
		sby(32'h2, 1'b1, 1'b1, 64 * TK, 72 * TK);
		check("reset_standby", 32'h1, {31'h0, host_reset_wire});
		sby(32'h0, 1'b0, 1'b0, 0, 72 * TK);
		fault_in <= 1'b1;
		wait_for(0, 1'b0, 70 * TK);
		check("fault_rst", 32'h1, {31'h0, n >= 59 * TK && n <= 65 * TK});
		check("int_masked", 32'h1, {31'h0, interrupt_wire});
		bus(1'b0, pmic_pkg::REG_STATUS, 32'h0, q);
		check("status", 32'h4, q);
		bus(1'b1, pmic_pkg::REG_MASK, 32'h3, q);
		repeat (2) @(posedge ref_clk);
		check("int_unmask", 32'h0, {31'h0, interrupt_wire});
		bus(1'b0, pmic_pkg::REG_SENSE, 32'h0, q);
		check("sense", 32'h18, q);
		bus(1'b1, pmic_pkg::REG_SENSE, 32'h1f, q);
		bus(1'b0, pmic_pkg::REG_SENSE, 32'h0, q);
		check("sense_kept", 32'h18, q);
		bus(1'b1, pmic_pkg::REG_STATUS, 32'h4, q);
		repeat (2) @(posedge ref_clk);
		check("int_clear", 32'h1, {31'h0, interrupt_wire});
		bus(1'b0, pmic_pkg::REG_STATUS, 32'h0, q);
		check("status_clear", 32'h0, q);
		fault_in <= 1'b0;
		power_on_input <= 1'b0;
		wait_for(2, 1'b0, 6 * TK);
		check("off_reset", 32'h0, {31'h0, host_reset_wire});
		bus(1'b0, pmic_pkg::REG_STATE, 32'h0, q);
		check("state_off", 32'h0, q);
		power_on_input <= 1'b1;
		wait_for(0, 1'b1, 40 * TK);
		check("restart", 32'h1, {31'h0, host_reset_wire});
		wd_fire <= 1'b1;
		wait_for(2, 1'b0, 6 * TK);
		@(posedge ref_clk);
		check("wdog_regs", 32'h0, {31'h0, regulators_enable});
		check("wdog_reset", 32'h0, {31'h0, host_reset_wire});
		wd_fire <= 1'b0;
		power_on_input <= 1'b0;
		repeat (4 * TK) @(posedge ref_clk);
		power_on_input <= 1'b1;
		wait_for(0, 1'b1, 40 * TK);
		check("restart_wdog", 32'h1, {31'h0, host_reset_wire});
		bus(1'b1, pmic_pkg::REG_CTRL, 32'h18, q);
		press <= 1'b1;
		repeat (15 * TK) @(posedge ref_clk);
		bus(1'b0, pmic_pkg::REG_STATUS, 32'h0, q);
		check("press_int", 32'h1, q);
		wait_for(2, 1'b0, 12 * TK);
		check("long_press", 32'h1, {31'h0, n >= 3 * TK});
		check("long_off", 32'h0, {31'h0, regulators_enable});
		bus(1'b0, pmic_pkg::REG_STATUS, 32'h0, q);
		check("btn_int_off", 32'h0, q);
		print_verdict();
	end
endmodule : test_pmic_control_pin_logic
